// ### hdl/atss_pkg.sv
/*
  Constants shared by the touch scan sequencer: RAM geometry, entry layout,
  mode encodings and timing counts.
  Assumes a single 250 MHz clock REF_CLK and a synchronous active-high reset.
*/
package atss_pkg;
  // ----------------------------------------------------------------
  // RAM geometry
  // ----------------------------------------------------------------
  localparam int RAM_BYTES  = 1024;
  localparam int RAM_WORDS  = RAM_BYTES / 4;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  // Result area starts at the upper half of the RAM
  localparam logic [7:0] RESULT_BASE = 8'h80;
  // ----------------------------------------------------------------
  // Configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_LP_BIT   = 31;  // Sensor belongs to a low-power widget
  localparam int CFG_LAST_BIT = 30;  // Last sensor of the frame
  localparam int THR_LSB      = 0;   // Touch threshold field
  localparam int THR_W        = 16;
  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_AUTO   = 2'h0,
    MODE_LEGACY = 2'h1,
    MODE_WAKE   = 2'h2
  } atss_mode_e;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 250;
  localparam int RES_ON_NS       = 40;   // Resource power-up settle time
  localparam int RES_ON_CYC      = (RES_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_DIV        = 256;  // Low-power timer tick divider
  localparam logic [15:0] DELAY_RESET   = 16'h0004;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0040;
endpackage : atss_pkg

// ### hdl/atss_ram.sv
/*
  Single-port 1 KB configuration and result RAM with registered read data.
  Assumes the controller holds one access per cycle.
*/
`timescale 1ns/1ps
module atss_ram (
  input wire logic REF_CLK,
  atss_ram_if.mem  bus
);
  logic [31:0] mem_q [atss_pkg::RAM_WORDS];
  logic [31:0] rdata_ff;

  // Write and registered read
  always_ff @(posedge REF_CLK) begin
    if (bus.en && bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
    if (bus.en) begin
      rdata_ff <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_ff;
endmodule // atss_ram

// ### hdl/atss_ram_if.sv
/*
  Interface between the sequencer and its RAM.
  Assumes one clock; read data return one cycle after the request.
*/
`timescale 1ns/1ps
interface atss_ram_if;
  logic        en;
  logic        we;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface : atss_ram_if

// ### hdl/atss_seq.sv
/*
  Autonomous touch scan sequencer: walks sensor configurations in its RAM,
  runs scans on the analog front end, stores results and signals the host.
  Assumes the front end answers SCAN_START with one SCAN_DONE pulse and a result.
*/
// Notes on behaviour
// - Legacy mode raises a done pulse after every single sensor scan.
// - A 1 KB RAM holds configurations and results, host loaded.
// - Autonomous mode fetches config, scans, stores result per sensor, unaided.
// - Host reads results only after the frame-done indication.
// - Autonomous mode can repeat frames and evaluate touches itself.
// - Wake mode scans low-power sensors slowly and evaluates internally.
// - Wake mode interrupts on activity and on timeout.
// - Autonomous frame mode is the reset default.
// - Resources power off after each frame and on before the next.
// - Low-power sensors are evaluated in hardware and wake the host.
// - A timer delay precedes each autonomous and wake frame and sets refresh interval.
`timescale 1ns/1ps
module atss_seq #(
  parameter int DELAY_W = 16
) (
  input  wire logic               REF_CLK,
  input  wire logic               RST,
  input  wire logic [1:0]         MODE,
  input  wire logic               PERIODIC,
  input  wire logic [DELAY_W-1:0] WAKE_DELAY,
  input  wire logic [15:0]        WAKE_TIMEOUT,
  input  wire logic               FRAME_START,
  input  wire logic               HOST_WE,
  input  wire logic [7:0]         HOST_ADDR,
  input  wire logic [31:0]        HOST_WDATA,
  input  wire logic               HOST_RE,
  output logic      [31:0]        HOST_RDATA,
  output logic                    SCAN_START,
  output logic      [31:0]        SCAN_CFG,
  input  wire logic               SCAN_DONE,
  input  wire logic [31:0]        SCAN_RESULT,
  output logic                    RES_EN,
  output logic                    BUSY,
  output logic                    SENSOR_IRQ,
  output logic                    FRAME_IRQ,
  output logic                    WAKE_IRQ,
  output logic                    TOUCH
);
  // ------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_POWER, ST_FETCH, ST_WAITCFG, ST_SCAN, ST_STORE, ST_END
  } atss_state_e;

  atss_state_e state_ff;
  logic [1:0]  mode_ff;
  logic [7:0]  idx_ff;
  logic [31:0] cfg_ff;
  logic [DELAY_W-1:0] delay_ff;
  logic [15:0] timeout_ff;
  logic [15:0] tick_ff;
  logic        tick;
  logic [7:0]  pwr_ff;
  logic        touch_seen_ff;
  logic        running_ff;
  logic        host_rd_ff;
  logic [31:0] res_hold_ff;  // Scan result kept from the done pulse until stored

  // ------------------------------------------------------------
  // Configuration and result RAM
  // ------------------------------------------------------------
  // One port shared by sequencer and host, so accesses never collide
  atss_ram_if ram ();

  atss_ram u_ram (
    .REF_CLK (REF_CLK),
    .bus     (ram)
  );

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Touch evaluation: result above threshold of the configuration
  function automatic logic is_touch(input logic [31:0] res, input logic [31:0] cfg);
    is_touch = res[15:0] > cfg[atss_pkg::THR_LSB +: atss_pkg::THR_W];
  endfunction

  // Entry closes the frame: marked last, or the configuration half is used up,
  // which keeps a missing last mark from walking into the result area
  function automatic logic is_final(input logic [31:0] cfg, input logic [7:0] idx);
    is_final = cfg[atss_pkg::CFG_LAST_BIT] || (idx == 8'(atss_pkg::RESULT_BASE - 1));
  endfunction

  // ------------------------------------------------------------
  // Low-power timer tick divider
  // ------------------------------------------------------------
  // Held at zero outside the delay state, so N ticks of delay always last
  // exactly N * TICK_DIV cycles, whatever the phase of the frame start
  always_ff @(posedge REF_CLK) begin
    if (RST || state_ff != ST_DELAY || tick_ff == 16'(atss_pkg::TICK_DIV - 1)) begin
      tick_ff <= 16'h0000;
    end else begin
      tick_ff <= tick_ff + 16'h0001;
    end
  end
  assign tick = (tick_ff == 16'(atss_pkg::TICK_DIV - 1));

  // ------------------------------------------------------------
  // RAM port: sequencer owns it while busy, host otherwise
  // ------------------------------------------------------------
  always_comb begin
    ram.en    = 1'b0;
    ram.we    = 1'b0;
    ram.addr  = HOST_ADDR;
    ram.wdata = HOST_WDATA;
    if (state_ff == ST_FETCH) begin
      ram.en   = 1'b1;
      ram.addr = idx_ff;
    end else if (state_ff == ST_STORE) begin
      ram.en    = 1'b1;
      ram.we    = 1'b1;
      ram.addr  = atss_pkg::RESULT_BASE + idx_ff;
      ram.wdata = res_hold_ff;
    end else if (!running_ff && (HOST_WE || HOST_RE)) begin
      // host access when idle
      // Host requests during a frame are dropped, never queued
      ram.en = 1'b1;
      ram.we = HOST_WE;
    end
  end

  // ------------------------------------------------------------
  // Host read data
  // ------------------------------------------------------------
  // RAM register then output register: data stand two cycles after the request
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      host_rd_ff <= 1'b0;
      HOST_RDATA <= 32'h0000_0000;
    end else begin
      host_rd_ff <= HOST_RE && !running_ff && state_ff == ST_IDLE;
      if (host_rd_ff) begin
        HOST_RDATA <= ram.rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  // One state walk serves all three modes; pulse outputs last a single cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_ff      <= ST_IDLE;
      mode_ff       <= atss_pkg::MODE_RESET;
      idx_ff        <= 8'h00;
      cfg_ff        <= 32'h0000_0000;
      res_hold_ff   <= 32'h0000_0000;
      delay_ff      <= '0;
      pwr_ff        <= 8'h00;
      running_ff    <= 1'b0;
      touch_seen_ff <= 1'b0;
      SCAN_START    <= 1'b0;
      SCAN_CFG      <= 32'h0000_0000;
      RES_EN        <= 1'b0;
      BUSY          <= 1'b0;
      SENSOR_IRQ    <= 1'b0;
      FRAME_IRQ     <= 1'b0;
      WAKE_IRQ      <= 1'b0;
      TOUCH         <= 1'b0;
    end else begin
      // Pulses default low and are raised only by the state that owns them
      SCAN_START <= 1'b0;
      SENSOR_IRQ <= 1'b0;
      FRAME_IRQ  <= 1'b0;
      WAKE_IRQ   <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (FRAME_START) begin
            mode_ff       <= MODE;
            idx_ff        <= 8'h00;
            running_ff    <= 1'b1;
            touch_seen_ff <= 1'b0;
            BUSY          <= 1'b1;
            delay_ff      <= WAKE_DELAY;
            // Settle count restarts here, since legacy frames bypass the delay
            pwr_ff        <= 8'h00;
            state_ff      <= (MODE == atss_pkg::MODE_LEGACY) ? ST_POWER : ST_DELAY;
          end
        end
        ST_DELAY: begin
          // refresh delay
          // Zero delay passes straight on; each tick takes one off the count
          if (delay_ff == '0) begin
            state_ff <= ST_POWER;
            pwr_ff   <= 8'h00;
          end else if (tick) begin
            delay_ff <= delay_ff - 1'b1;
          end
        end
        ST_POWER: begin
          RES_EN <= 1'b1;
          if (pwr_ff == 8'(atss_pkg::RES_ON_CYC)) begin
            state_ff <= ST_FETCH;
          end else begin
            pwr_ff <= pwr_ff + 8'h01;
          end
        end
        ST_FETCH: begin
          // fetch configuration
          // Read data come back from the RAM register one cycle later
          state_ff <= ST_WAITCFG;
        end
        ST_WAITCFG: begin
          cfg_ff <= ram.rdata;
          // wake mode runs only low-power sensors
          if (mode_ff == atss_pkg::MODE_WAKE && !ram.rdata[atss_pkg::CFG_LP_BIT]) begin
            // Skipped entries still advance the index
            state_ff <= is_final(ram.rdata, idx_ff) ? ST_END : ST_FETCH;
            idx_ff   <= idx_ff + 8'h01;
          end else begin
            SCAN_CFG   <= ram.rdata;
            SCAN_START <= 1'b1;
            state_ff   <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          // Front end result is only valid alongside the done pulse
          if (SCAN_DONE) begin
            res_hold_ff <= SCAN_RESULT;
            state_ff    <= ST_STORE;
            if (is_touch(SCAN_RESULT, cfg_ff)) begin
              touch_seen_ff <= 1'b1;
            end
          end
        end
        ST_STORE: begin
          if (mode_ff == atss_pkg::MODE_LEGACY) begin
            SENSOR_IRQ <= 1'b1;
            state_ff   <= ST_END;
          end else if (is_final(cfg_ff, idx_ff)) begin
            // Last entry written, frame complete
            state_ff <= ST_END;
          end else begin
            idx_ff   <= idx_ff + 8'h01;
            state_ff <= ST_FETCH;
          end
        end
        ST_END: begin
          RES_EN     <= 1'b0;
          BUSY       <= 1'b0;
          running_ff <= 1'b0;
          TOUCH      <= touch_seen_ff;
          if (mode_ff != atss_pkg::MODE_LEGACY) begin
            FRAME_IRQ <= 1'b1;
          end
          if (mode_ff == atss_pkg::MODE_WAKE && touch_seen_ff) begin
            WAKE_IRQ <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (mode_ff == atss_pkg::MODE_WAKE && timeout_ff == 16'h0000) begin
            // wake on timeout
            // Tested before the count drops, so a load of N allows N + 1 frames
            WAKE_IRQ <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (PERIODIC && mode_ff != atss_pkg::MODE_LEGACY) begin
            running_ff    <= 1'b1;
            BUSY          <= 1'b1;
            idx_ff        <= 8'h00;
            touch_seen_ff <= 1'b0;
            delay_ff      <= WAKE_DELAY;
            state_ff      <= ST_DELAY;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Wake timeout in frames
  // ------------------------------------------------------------
  // Loaded at each accepted start, counted down once per finished frame
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      timeout_ff <= atss_pkg::TIMEOUT_RESET;
    end else if (state_ff == ST_IDLE && FRAME_START) begin
      timeout_ff <= WAKE_TIMEOUT;
    end else if (state_ff == ST_END && timeout_ff != 16'h0000) begin
      timeout_ff <= timeout_ff - 16'h0001;
    end
  end
endmodule // atss_seq

// ### verif/atss_fe_model.sv
/*
  Front end model: answers each scan request with one done pulse and a result.
  Assumes SCAN_START pulses from atss_seq, one scan at a time.
*/
`timescale 1ns/1ps
module atss_fe_model #(
  parameter int LAT = 6
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [31:0] cfg,
  output logic             done,
  output logic      [31:0] result
);
  logic [3:0]  cnt_ff;
  logic [31:0] cfg_ff;
  // Scan timer; bit 29 of the config asks for a touch-sized result
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      done   <= 1'b0;
      result <= 32'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_ff <= 4'(LAT);
        cfg_ff <= cfg;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
      if (cnt_ff == 4'h1) begin
        done   <= 1'b1;
        result <= {16'h00a5, cfg_ff[15:0] + {15'h0, cfg_ff[29]}};
      end else begin
        result <= ~result; // Result is not held outside the done pulse
      end
    end
  end
endmodule // atss_fe_model

// ### verif/atss_seq_assertions.sv
/*
  Port checker for atss_seq.
  Assumes binding to atss_seq and MODE held steady through a frame.
*/
`timescale 1ns/1ps
module atss_seq_assertions (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic [1:0] MODE,
  input wire logic       PERIODIC,
  input wire logic       FRAME_START,
  input wire logic       SCAN_START,
  input wire logic       RES_EN,
  input wire logic       BUSY,
  input wire logic       SENSOR_IRQ,
  input wire logic       FRAME_IRQ,
  input wire logic       WAKE_IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_start_sets_busy: assert property (FRAME_START && !BUSY && !PERIODIC |=> BUSY)
    else $error("busy missing after frame start");
  a_scan_when_on: assert property (SCAN_START |-> BUSY && RES_EN)
    else $error("scan outside powered frame");
  a_settle_first: assert property ($rose(RES_EN) |-> !SCAN_START [*8])
    else $error("scan before resources settle");
  a_res_off_end: assert property ($fell(BUSY) && !PERIODIC |-> ##[0:2] !RES_EN)
    else $error("resources left on after frame");
  a_sensor_irq_legacy: assert property (SENSOR_IRQ |-> MODE == atss_pkg::MODE_LEGACY && !FRAME_IRQ)
    else $error("sensor interrupt outside legacy mode");
  a_frame_irq_mode: assert property (FRAME_IRQ |-> MODE != atss_pkg::MODE_LEGACY)
    else $error("frame interrupt in legacy mode");
  a_wake_irq_mode: assert property (WAKE_IRQ |-> MODE == atss_pkg::MODE_WAKE)
    else $error("wake interrupt outside wake mode");
  a_irq_one_cycle: assert property (FRAME_IRQ || SENSOR_IRQ || WAKE_IRQ |=> !(FRAME_IRQ || SENSOR_IRQ || WAKE_IRQ))
    else $error("interrupt wider than one cycle");
  a_scan_pulse: assert property (SCAN_START |=> !SCAN_START)
    else $error("scan start wider than one cycle");
endmodule // atss_seq_assertions
bind atss_seq atss_seq_assertions i_atss_seq_assertions (.REF_CLK(REF_CLK), .RST(RST), .MODE(MODE),
  .PERIODIC(PERIODIC), .FRAME_START(FRAME_START), .SCAN_START(SCAN_START), .RES_EN(RES_EN), .BUSY(BUSY),
  .SENSOR_IRQ(SENSOR_IRQ), .FRAME_IRQ(FRAME_IRQ), .WAKE_IRQ(WAKE_IRQ));

// ### verif/testbench.sv
/*
  Self-checking bench for atss_seq with a front end model.
  Assumes a 250 MHz REF_CLK and synchronous reset.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        REF_CLK = 0, RST = 1, PERIODIC = 0, FRAME_START = 0, HOST_WE = 0, HOST_RE = 0;
  logic [1:0]  MODE = atss_pkg::MODE_RESET;
  logic [15:0] WAKE_DELAY = 0, WAKE_TIMEOUT = 16'h0002;
  logic [7:0]  HOST_ADDR = 0;
  logic [31:0] HOST_WDATA = 0, HOST_RDATA, SCAN_CFG, SCAN_RESULT;
  logic        SCAN_START, SCAN_DONE, RES_EN, BUSY, SENSOR_IRQ, FRAME_IRQ, WAKE_IRQ, TOUCH;
  logic [2:0]  irqs;
  int          errors = 0, cmp_count = 0, sc, f0, f1;
  assign irqs = {WAKE_IRQ, SENSOR_IRQ, FRAME_IRQ};
  always #2 REF_CLK = ~REF_CLK;
  atss_seq i_atss_seq (.REF_CLK(REF_CLK), .RST(RST), .MODE(MODE), .PERIODIC(PERIODIC), .WAKE_DELAY(WAKE_DELAY),
    .WAKE_TIMEOUT(WAKE_TIMEOUT), .FRAME_START(FRAME_START), .HOST_WE(HOST_WE), .HOST_ADDR(HOST_ADDR),
    .HOST_WDATA(HOST_WDATA), .HOST_RE(HOST_RE), .HOST_RDATA(HOST_RDATA), .SCAN_START(SCAN_START),
    .SCAN_CFG(SCAN_CFG), .SCAN_DONE(SCAN_DONE), .SCAN_RESULT(SCAN_RESULT), .RES_EN(RES_EN), .BUSY(BUSY),
    .SENSOR_IRQ(SENSOR_IRQ), .FRAME_IRQ(FRAME_IRQ), .WAKE_IRQ(WAKE_IRQ), .TOUCH(TOUCH));
  atss_fe_model i_atss_fe_model (.clk(REF_CLK), .rst(RST), .start(SCAN_START), .cfg(SCAN_CFG),
    .done(SCAN_DONE), .result(SCAN_RESULT));
  // Host RAM write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK) {HOST_WE, HOST_ADDR, HOST_WDATA} <= {1'b1, a, d};
    @(posedge REF_CLK) HOST_WE <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge REF_CLK) {HOST_RE, HOST_ADDR} <= {1'b1, a};
    @(posedge REF_CLK) HOST_RE <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    // Read at the edge: data were registered one edge earlier and still stand
    `CHK("ram word", e, HOST_RDATA)
  endtask
  // Start a frame, count scans until the chosen interrupt has come need times
  task automatic run(input int sel, input int need, input bit poke, output int scans, output int first);
    int n, hits;
    scans = 0;
    first = -1;
    hits = 0;
    @(posedge REF_CLK) FRAME_START <= 1'b1;
    @(posedge REF_CLK) FRAME_START <= 1'b0;
    for (n = 0; n < 20000 && hits < need; n++) begin
      @(posedge REF_CLK);
      if (poke && n == 4) {FRAME_START, HOST_WE, HOST_ADDR, HOST_WDATA} <= {2'b11, 8'h00, 32'hffff_ffff};
      if (poke && n == 5) {FRAME_START, HOST_WE} <= 2'b00;
      if (SCAN_START === 1'b1) begin
        scans++;
        if (first < 0) first = n;
      end
      if (irqs[sel] === 1'b1) hits++;
    end
    `CHK("interrupt count", need, hits)
    repeat (3) @(posedge REF_CLK);
  endtask
  // Default mode frame of three sensors with refused requests while busy
  task automatic t_auto;
    wr(8'h00, 32'h2000_0010);
    wr(8'h01, 32'h0000_0020);
    wr(8'h02, 32'h4000_0030);
    wr(8'hff, 32'h1234_5678);
    rd(8'hff, 32'h1234_5678);
    run(0, 1, 1, sc, f0);
    `CHK("scans", 3, sc)
    `CHK("busy", 1'b0, BUSY)
    `CHK("res_en", 1'b0, RES_EN)
    `CHK("touch", 1'b1, TOUCH)
    rd(8'h80, 32'h00a5_0011);
    rd(8'h82, 32'h00a5_0030);
    rd(8'h00, 32'h2000_0010);
    repeat (40) @(posedge REF_CLK);
    `CHK("no restart", 1'b0, BUSY)
    WAKE_DELAY <= 16'h0001;
    run(0, 1, 0, sc, f1);
    `CHK("delay span", atss_pkg::TICK_DIV, f1 - f0)
    WAKE_DELAY <= 16'h0000;
  endtask
  // Legacy: one sensor per host start, host reconfigures between
  task automatic t_legacy;
    MODE <= atss_pkg::MODE_LEGACY;
    wr(8'h00, 32'h0000_0044);
    run(1, 1, 0, sc, f0);
    `CHK("legacy scans", 1, sc)
    rd(8'h80, 32'h00a5_0044);
    wr(8'h00, 32'h2000_0055);
    run(1, 1, 0, sc, f0);
    rd(8'h80, 32'h00a5_0056);
  endtask
  // Periodic frames without host starts
  task automatic t_periodic;
    MODE <= atss_pkg::MODE_AUTO;
    PERIODIC <= 1'b1;
    run(0, 2, 0, sc, f0);
    PERIODIC <= 1'b0;
    repeat (300) @(posedge REF_CLK);
    `CHK("periodic stop", 1'b0, BUSY)
  endtask
  // Wake mode: only low-power sensors, timeout then touch
  task automatic t_wake;
    MODE <= atss_pkg::MODE_WAKE;
    PERIODIC <= 1'b1;
    wr(8'h00, 32'h0000_0010);
    wr(8'h01, 32'hc000_0010);
    run(2, 1, 0, sc, f0);
    // Timeout of two is tested before it counts, so three frames run
    `CHK("timeout scans", 3, sc)
    `CHK("no touch", 1'b0, TOUCH)
    WAKE_TIMEOUT <= 16'h0008;
    wr(8'h01, 32'he000_0010);
    run(2, 1, 0, sc, f0);
    `CHK("touch scans", 1, sc)
    `CHK("touch", 1'b1, TOUCH)
    PERIODIC <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    #1 `CHK("reset busy", 1'b0, BUSY)
    t_auto();
    t_legacy();
    t_periodic();
    t_wake();
    final_report();
  end
  // Watchdog
  initial begin
    // About ten times the expected length of all scenarios
    #40us;
    errors++;
    final_report();
  end
endmodule // testbench
